// File: bench/dcf_deep_fifo_tb_top.sv
/*
 self-checking bench for the deep fifo, small depth, shared clock.
 assumes the far model drives enables and data.
*/
`timescale 1ns/1ns
module dcf_deep_fifo_tb_top;
    localparam int DEPTH = 16;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic oe_n = 1'b0;
    logic [8:0] wbus, rbus, seen, last_w;
    logic [8:0] rbus_s;
    logic wa_n, wb, ra_n, rb_n, bus_oe_n, e_n, f_n, ae_n, af_n;
    int n_errors = 0;
    int n_tests = 0;
    logic [8:0] exp_q[$];
    always #4 mclk = ~mclk;
    // one clock on both sides
    dcf_deep_fifo #(.DEPTH(DEPTH)) dut_u (
        .i_mclk(mclk), .i_rd_clk(mclk), .i_rst_n(rst_n),
        .i_write_bus(wbus), .i_write_enable_a_n(wa_n),
        .i_write_enable_b(wb), .i_read_enable_a_n(ra_n),
        .i_read_enable_b_n(rb_n), .i_output_drive_enable_n(oe_n),
        .o_read_bus(rbus), .o_read_bus_oe_n(bus_oe_n),
        .o_empty_flag_n(e_n), .o_full_flag_n(f_n),
        .o_almost_empty_flag_n(ae_n), .o_almost_full_flag_n(af_n)
    );
    // a second device carries the inverted copy of the same word
    dcf_deep_fifo #(.DEPTH(DEPTH)) slice_u (
        .i_mclk(mclk), .i_rd_clk(mclk), .i_rst_n(rst_n),
        .i_write_bus(~wbus), .i_write_enable_a_n(wa_n),
        .i_write_enable_b(wb), .i_read_enable_a_n(ra_n),
        .i_read_enable_b_n(rb_n), .i_output_drive_enable_n(oe_n),
        .o_read_bus(rbus_s), .o_read_bus_oe_n(),
        .o_empty_flag_n(), .o_full_flag_n(),
        .o_almost_empty_flag_n(), .o_almost_full_flag_n()
    );
    dcf_far_model far_u (
        .i_clk(mclk), .i_empty_n(e_n), .i_read_bus(rbus), .i_oe_n(bus_oe_n),
        .o_write_bus(wbus), .o_write_enable_a_n(wa_n),
        .o_write_enable_b(wb), .o_read_enable_a_n(ra_n),
        .o_read_enable_b_n(rb_n), .o_bus_seen(seen)
    );
    task automatic check(input logic [8:0] got, input logic [8:0] want);
        n_tests++;
        if (got !== want) begin
            n_errors++;
            $display("[ERR] %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic settle;
        repeat (8) @(posedge mclk);
        #1;
    endtask
    task automatic do_reset(input logic strap);
        @(posedge mclk);
        rst_n <= 1'b0;
        far_u.wr(1'b1, strap, 9'h000);
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic push(input logic [8:0] d);
        far_u.wr(1'b0, 1'b1, d);
        exp_q.push_back(d);
    endtask
    task automatic push_n(input int n, input logic [8:0] base);
        for (int i = 0; i < n; i++) begin
            push(base + 9'(i));
        end
        far_u.wr(1'b1, 1'b1, 9'h000);
        settle();
    endtask
    task automatic drain;
        logic [8:0] w;
        logic ok;
        while (exp_q.size() > 0) begin
            far_u.rd(1'b0, w, ok);
            check(9'(ok), 9'h001);
            last_w = exp_q.pop_front();
            check(w, last_w);
            check(rbus_s, ~last_w);
        end
        settle();
    endtask
    task automatic t_reset_values;
        do_reset(1'b1);
        check({5'h00, e_n, f_n, ae_n, af_n}, 9'h005);
        check(rbus, 9'h000);
        $display("reset values done");
    endtask
    task automatic t_default_thr;
        logic [8:0] w;
        logic ok;
        push(9'h1ff);
        push(9'h100);
        push_n(5, 9'h0f0);
        check({8'h00, ae_n}, 9'h000);
        check({8'h00, e_n}, 9'h001);
        push_n(1, 9'h055);
        check({8'h00, ae_n}, 9'h001);
        far_u.wr(1'b0, 1'b0, 9'h033);
        far_u.wr(1'b1, 1'b1, 9'h0aa);
        settle();
        drain();
        check({7'h00, e_n, ae_n}, 9'h000);
        far_u.rd(1'b0, w, ok);
        check(9'(ok), 9'h000);
        check(w, last_w);
        $display("default thresholds done");
    endtask
    task automatic t_full;
        push_n(16, 9'h010);
        push_n(2, 9'h180);
        check({7'h00, f_n, af_n}, 9'h000);
        far_u.wr(1'b0, 1'b1, 9'h0aa);
        far_u.wr(1'b1, 1'b1, 9'h000);
        settle();
        check({8'h00, f_n}, 9'h000);
        @(posedge mclk);
        oe_n <= 1'b1;
        #1;
        check({8'h00, bus_oe_n}, 9'h001);
        check(seen, ~last_w);
        @(posedge mclk);
        oe_n <= 1'b0;
        #1;
        check(seen, last_w);
        drain();
        check({6'h00, e_n, f_n, af_n}, 9'h003);
        $display("full and output enable done");
    endtask
    task automatic t_thr_mode;
        logic [8:0] w;
        logic ok;
        logic [8:0] want[4];
        want = '{9'h002, 9'h000, 9'h003, 9'h000};
        do_reset(1'b0);
        check({7'h00, e_n, ae_n}, 9'h000);
        far_u.wr(1'b0, 1'b0, 9'h005);
        far_u.wr(1'b0, 1'b0, 9'h000);
        far_u.wr(1'b0, 1'b0, 9'h003);
        far_u.wr(1'b0, 1'b0, 9'h000);
        far_u.wr(1'b0, 1'b0, 9'h002);
        far_u.wr(1'b1, 1'b0, 9'h000);
        settle();
        for (int i = 0; i < 4; i++) begin
            far_u.rd(1'b1, w, ok);
            check(w, want[i]);
        end
        far_u.wr(1'b1, 1'b1, 9'h000);
        settle();
        far_u.wr(1'b0, 1'b0, 9'h000);
        far_u.wr(1'b1, 1'b1, 9'h000);
        push_n(2, 9'h120);
        check({8'h00, ae_n}, 9'h000);
        push_n(1, 9'h130);
        check({8'h00, ae_n}, 9'h001);
        push_n(11, 9'h040);
        check({8'h00, af_n}, 9'h001);
        push_n(1, 9'h1a5);
        check({8'h00, af_n}, 9'h000);
        drain();
        $display("threshold mode done");
    endtask
    initial begin
        last_w = 9'h000;
        t_reset_values();
        t_default_thr();
        t_full();
        t_thr_mode();
        give_verdict();
    end
    initial begin
        #100000;
        n_errors++;
        give_verdict();
    end
endmodule

// File: bench/dcf_far_model.sv
/*
 producer and consumer logic facing the fifo, sharing one clock.
 assumes the bench calls its tasks and owns reset and output enable.
*/
`timescale 1ns/1ns
module dcf_far_model (
    input wire logic i_clk,
    input wire logic i_empty_n,
    input wire logic [8:0] i_read_bus,
    input wire logic i_oe_n,
    output logic [8:0] o_write_bus,
    output logic o_write_enable_a_n,
    output logic o_write_enable_b,
    output logic o_read_enable_a_n,
    output logic o_read_enable_b_n,
    output logic [8:0] o_bus_seen
);
    logic [8:0] last = 9'h000;
    initial begin
        o_write_bus = 9'h000;
        o_write_enable_a_n = 1'b1;
        o_write_enable_b = 1'b1;
        o_read_enable_a_n = 1'b1;
        o_read_enable_b_n = 1'b1;
    end
    // floated bus shows the inverse of the last driven value
    always_comb o_bus_seen = i_oe_n ? ~last : i_read_bus;
    always @(posedge i_clk) begin
        if (!i_oe_n) last <= i_read_bus;
    end
    // one write cycle; enable b doubles as strap and load select
    task automatic wr(input logic a_n, input logic b, input logic [8:0] d);
        @(posedge i_clk);
        o_write_enable_a_n <= a_n;
        o_write_enable_b <= b;
        o_write_bus <= d;
    endtask
    // one read cycle; thr skips the wait for data
    task automatic rd(input logic thr, output logic [8:0] w, output logic ok);
        int n;
        n = 0;
        while (!thr && i_empty_n !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        ok = thr || (i_empty_n === 1'b1);
        @(posedge i_clk);
        o_read_enable_a_n <= 1'b0;
        o_read_enable_b_n <= 1'b0;
        @(posedge i_clk);
        o_read_enable_a_n <= 1'b1;
        o_read_enable_b_n <= 1'b1;
        #1;
        w = o_bus_seen;
    endtask
endmodule

// File: hdl/dcf_deep_fifo.sv
/*
 deep 9-bit fifo with separate write clock (i_mclk) and read clock,
 strap-selected dual write enable or threshold programming, four flags
 and a three-state read bus enable.
 assumes producer logic on i_mclk, consumer logic on i_rd_clk, and one
 reset after power-up with the strap level held until the first i_mclk edge after its release.
*/
// Function
// RULE1: nine-bit write and read buses, full words
// RULE2: depth parameter, 16K or 32K words
// RULE3: dual mode stores on enable a low, b high
// RULE4: threshold mode stores on enable a alone; the code also needs enable b high
// RULE5: strap on enable b picks the mode
// RULE6: one word accepted every write clock
// RULE7: writes ignored while full
// RULE8: read only when both enables low, not empty
// RULE9: load select low writes threshold register
// RULE10: load select low reads threshold register
// RULE11: empty flag on read clock
// RULE12: full flag on write clock
// RULE13: almost empty flag on read clock
// RULE14: almost full flag on write clock
// RULE15: reset empties the fifo
// RULE16: output enable high floats the read bus
// RULE17: clocks may be shared or unrelated
// RULE18: depth expansion drives enables externally
// RULE19: width expansion places devices side by side
// RULE20: threshold registers selected in turn, wrapping
// RULE21: thresholds default to seven
// RULE22: almost empty low at threshold or fewer
// RULE23: almost full high when free exceeds threshold
// RULE24: reset clears pointers and restores thresholds
// RULE25: gray pointers with two-flop synchronisers
`timescale 1ns/1ns
module dcf_deep_fifo #(
    parameter int DEPTH = dcf_pkg::DEPTH_16K
) (
    input wire logic i_mclk,
    input wire logic i_rd_clk,
    input wire logic i_rst_n,
    input wire logic [8:0] i_write_bus,
    input wire logic i_write_enable_a_n,
    input wire logic i_write_enable_b,
    input wire logic i_read_enable_a_n,
    input wire logic i_read_enable_b_n,
    input wire logic i_output_drive_enable_n,
    output logic [8:0] o_read_bus,
    output logic o_read_bus_oe_n,
    output logic o_empty_flag_n,
    output logic o_full_flag_n,
    output logic o_almost_empty_flag_n,
    output logic o_almost_full_flag_n
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;

    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        for (int i = PW - 1; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i + 1]);
        end
        return b;
    endfunction

    function automatic dcf_pkg::dcf_thr_sel_t next_sel(
        input dcf_pkg::dcf_thr_sel_t s
    );
        unique case (s)
            dcf_pkg::SEL_EMPTY_LO: return dcf_pkg::SEL_EMPTY_HI;
            dcf_pkg::SEL_EMPTY_HI: return dcf_pkg::SEL_FULL_LO;
            dcf_pkg::SEL_FULL_LO: return dcf_pkg::SEL_FULL_HI;
            dcf_pkg::SEL_FULL_HI: return dcf_pkg::SEL_EMPTY_LO;
        endcase
    endfunction

    // storage and threshold registers
    logic [8:0] mem [DEPTH];
    logic [7:0] thr [4];

    // write clock domain
    logic mode_dual;
    logic mode_pending;
    logic wr_fifo;
    logic wr_thr;
    logic [PW-1:0] wptr;
    logic [PW-1:0] wptr_gray;
    logic [PW-1:0] next_wptr;
    logic [PW-1:0] rg_w1;
    logic [PW-1:0] rg_w2;
    logic [PW-1:0] rptr_w;
    logic [PW-1:0] used_next;
    logic [15:0] free_now;
    logic [15:0] m_val;
    dcf_pkg::dcf_thr_sel_t wsel;

    // read clock domain
    logic [PW-1:0] rptr;
    logic [PW-1:0] rptr_gray;
    logic [PW-1:0] wg_r1;
    logic [PW-1:0] wg_r2;
    logic [PW-1:0] wptr_r;
    logic ld_r1;
    logic ld_r2;
    logic md_r1;
    logic md_r2;
    logic mem_avail;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [8:0] buf_out_data;
    logic [1:0] buf_count;
    logic ren;
    logic thr_rd;
    logic fifo_rd;
    logic [15:0] count_r;
    logic [15:0] n_val;
    dcf_pkg::dcf_thr_sel_t rsel;

    // strap caught at the first write clock edge after reset release
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_dual <= dcf_pkg::MODE_DUAL_RESET;
            mode_pending <= 1'b1;
        end else if (mode_pending) begin
            mode_dual <= i_write_enable_b; // RULE5
            mode_pending <= 1'b0;
        end
    end

    // both modes store with enable a low and enable b high
    assign wr_fifo = ~mode_pending & ~i_write_enable_a_n
        & i_write_enable_b & o_full_flag_n; // RULE3 RULE4 RULE7
    assign wr_thr = ~mode_pending & ~mode_dual & ~i_write_enable_a_n
        & ~i_write_enable_b; // RULE9
    assign next_wptr = wptr + PW'(wr_fifo); // RULE6

    always_ff @(posedge i_mclk) begin
        if (wr_fifo) begin
            mem[wptr[AW-1:0]] <= i_write_bus; // RULE1 RULE2
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wptr <= '0; // RULE15 RULE24
            wptr_gray <= '0;
        end else begin
            wptr <= next_wptr;
            wptr_gray <= bin2gray(next_wptr); // RULE25
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rg_w1 <= '0;
            rg_w2 <= '0;
        end else begin
            rg_w1 <= rptr_gray; // RULE25 RULE17
            rg_w2 <= rg_w1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            thr[0] <= dcf_pkg::THR_DEF_LO; // RULE21 RULE24
            thr[1] <= dcf_pkg::THR_DEF_HI;
            thr[2] <= dcf_pkg::THR_DEF_LO;
            thr[3] <= dcf_pkg::THR_DEF_HI;
            wsel <= dcf_pkg::SEL_EMPTY_LO;
        end else if (wr_thr) begin
            thr[wsel] <= i_write_bus[7:0]; // RULE9
            wsel <= next_sel(wsel); // RULE20
        end
    end

    assign rptr_w = gray2bin(rg_w2);
    assign used_next = next_wptr - rptr_w;
    assign free_now = 16'(DEPTH) - 16'(next_wptr - rptr_w);
    assign m_val = {thr[3], thr[2]};

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_full_flag_n <= 1'b1;
            o_almost_full_flag_n <= 1'b1;
        end else begin
            o_full_flag_n <= (used_next != PW'(DEPTH)); // RULE12
            o_almost_full_flag_n <= (free_now > m_val); // RULE14 RULE23
        end
    end

    // read clock domain synchronisers
    always_ff @(posedge i_rd_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wg_r1 <= '0;
            wg_r2 <= '0;
            ld_r1 <= 1'b1;
            ld_r2 <= 1'b1;
            md_r1 <= dcf_pkg::MODE_DUAL_RESET;
            md_r2 <= dcf_pkg::MODE_DUAL_RESET;
        end else begin
            wg_r1 <= wptr_gray; // RULE25 RULE17
            wg_r2 <= wg_r1;
            ld_r1 <= i_write_enable_b;
            ld_r2 <= ld_r1;
            md_r1 <= mode_dual;
            md_r2 <= md_r1;
        end
    end

    assign wptr_r = gray2bin(wg_r2);
    assign mem_avail = (wptr_r != rptr);

    // prefetch into the two-entry buffer
    dcf_pair_buf #(
        .W(dcf_pkg::DATA_W),
        .N(dcf_pkg::BUF_DEPTH)
    ) u_buf (
        .i_clk(i_rd_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(mem_avail),
        .o_in_ready(buf_in_ready),
        .i_in_data(mem[rptr[AW-1:0]]),
        .o_out_valid(buf_out_valid),
        .i_out_ready(fifo_rd),
        .o_out_data(buf_out_data),
        .o_count(buf_count)
    );

    always_ff @(posedge i_rd_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rptr <= '0; // RULE15 RULE24
            rptr_gray <= '0;
        end else if (mem_avail && buf_in_ready) begin
            rptr <= rptr + PW'(1);
            rptr_gray <= bin2gray(rptr + PW'(1)); // RULE25
        end
    end

    assign ren = ~i_read_enable_a_n & ~i_read_enable_b_n;
    assign thr_rd = ren & ~md_r2 & ~ld_r2; // RULE10
    assign fifo_rd = ren & ~thr_rd & buf_out_valid; // RULE8

    always_ff @(posedge i_rd_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_read_bus <= dcf_pkg::BUS_RESET;
            rsel <= dcf_pkg::SEL_EMPTY_LO;
        end else if (thr_rd) begin
            o_read_bus <= {1'b0, thr[rsel]}; // RULE10
            rsel <= next_sel(rsel); // RULE20
        end else if (fifo_rd) begin
            o_read_bus <= buf_out_data; // RULE8 RULE1
        end
    end

    assign o_empty_flag_n = buf_out_valid; // RULE11
    assign o_read_bus_oe_n = i_output_drive_enable_n; // RULE16
    assign count_r = 16'(wptr_r - rptr) + 16'(buf_count);
    assign n_val = {thr[1], thr[0]};

    always_ff @(posedge i_rd_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_almost_empty_flag_n <= 1'b0;
        end else begin
            o_almost_empty_flag_n <= (count_r > n_val); // RULE13 RULE22
        end
    end

    sequence s_four_loads;
        wr_thr [*4];
    endsequence

    property p_mode_capture;
        @(posedge i_mclk) disable iff (!i_rst_n)
        $fell(mode_pending) |-> mode_dual == $past(i_write_enable_b);
    endproperty
    a_mode_capture: assert property (p_mode_capture) // RULE5
        else $error("mode not taken from strap");

    property p_full_blocks;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !o_full_flag_n |=> wptr == $past(wptr);
    endproperty
    a_full_blocks: assert property (p_full_blocks) // RULE7
        else $error("write taken while full");

    property p_write_step;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!mode_pending && !i_write_enable_a_n && i_write_enable_b
            && o_full_flag_n) |=> wptr == $past(wptr) + PW'(1);
    endproperty
    a_write_step: assert property (p_write_step) // RULE3
        else $error("write not accepted");

    property p_full_level;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !o_full_flag_n |-> (wptr - $past(rptr_w)) == PW'(DEPTH);
    endproperty
    a_full_level: assert property (p_full_level) // RULE12
        else $error("full flag without full buffer");

    property p_thr_write;
        @(posedge i_mclk) disable iff (!i_rst_n)
        wr_thr |=> thr[$past(wsel)] == $past(i_write_bus[7:0]);
    endproperty
    a_thr_write: assert property (p_thr_write) // RULE9
        else $error("threshold register not written");

    property p_sel_wrap;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_four_loads |=> wsel == $past(wsel, 4);
    endproperty
    a_sel_wrap: assert property (p_sel_wrap) // RULE20
        else $error("selection did not wrap after four loads");

    property p_empty_hold;
        @(posedge i_rd_clk) disable iff (!i_rst_n)
        (!o_empty_flag_n && !thr_rd) |=> $stable(o_read_bus);
    endproperty
    a_empty_hold: assert property (p_empty_hold) // RULE8
        else $error("read bus changed while empty");

    property p_read_word;
        @(posedge i_rd_clk) disable iff (!i_rst_n)
        fifo_rd |=> o_read_bus == $past(buf_out_data);
    endproperty
    a_read_word: assert property (p_read_word) // RULE8
        else $error("read bus missed the next word");

    property p_almost_empty;
        @(posedge i_rd_clk) disable iff (!i_rst_n)
        ($past(count_r) <= $past(n_val)) |-> !o_almost_empty_flag_n;
    endproperty
    a_almost_empty: assert property (p_almost_empty) // RULE22
        else $error("almost empty flag high at threshold");

    property p_almost_full;
        @(posedge i_mclk) disable iff (!i_rst_n)
        ($past(free_now) > $past(m_val)) |-> o_almost_full_flag_n;
    endproperty
    a_almost_full: assert property (p_almost_full) // RULE23
        else $error("almost full flag low with room above threshold");
endmodule

// File: hdl/dcf_pair_buf.sv
/*
 two-entry buffer with valid and ready on both sides; stalls its source
 when both entries are taken.
 assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module dcf_pair_buf #(
    parameter int W = 9,
    parameter int N = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data,
    output logic [$clog2(N):0] o_count
);
    localparam int IW = $clog2(N);

    logic [W-1:0] store [N];
    logic [IW-1:0] wr_idx;
    logic [IW-1:0] rd_idx;
    logic [IW:0] count;
    logic push;
    logic pop;

    function automatic logic [IW-1:0] inc_idx(input logic [IW-1:0] idx);
        if (idx == IW'(N - 1)) begin
            return '0;
        end
        return idx + IW'(1);
    endfunction

    assign o_in_ready = (count != (IW + 1)'(N));
    assign o_out_valid = (count != '0);
    assign o_out_data = store[rd_idx];
    assign o_count = count;
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            store[wr_idx] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_idx <= inc_idx(wr_idx);
            end
            if (pop) begin
                rd_idx <= inc_idx(rd_idx);
            end
            count <= count + (IW + 1)'(push) - (IW + 1)'(pop);
        end
    end
endmodule

// File: inc/dcf_pkg.sv
/*
 package for the deep dual-clock fifo: widths, depths, reset values and
 the threshold register selection type.
 assumes nothing beyond a systemverilog compiler.
*/
package dcf_pkg;
    localparam int DATA_W = 9;
    localparam int THR_W = 8;
    localparam int CNT_W = 16;
    localparam int DEPTH_16K = 16384;
    localparam int DEPTH_32K = 32768;
    localparam int BUF_DEPTH = 2;
    localparam logic [7:0] THR_DEF_LO = 8'h07;
    localparam logic [7:0] THR_DEF_HI = 8'h00;
    localparam logic MODE_DUAL_RESET = 1'b1;
    localparam logic [8:0] BUS_RESET = 9'h000;

    typedef enum logic [1:0] {
        SEL_EMPTY_LO,
        SEL_EMPTY_HI,
        SEL_FULL_LO,
        SEL_FULL_HI
    } dcf_thr_sel_t;
endpackage
